/* File: hw/pin_channel_pkg.sv */
package pin_channel_pkg;

    // Serial control word geometry
    localparam int WORD_BITS = 12;
    localparam int MODE_BITS = 6;
    localparam int CHANNELS = 4;
    localparam int SELECT_LSB = 8;
    localparam int SYNC_STAGES = 3;

    // Mode bit positions inside the control word
    localparam int TERM_BIT = 0;
    localparam int LOW_LEAK_BIT = 1;
    localparam int SENSE_BIT = 2;
    localparam int FORCE_BIT = 3;
    localparam int LOAD_LOW_BIT = 4;
    localparam int LOAD_HIGH_BIT = 5;

    // Power-up values: mode bits clear, every channel selected
    localparam logic [11:0] WORD_RESET = 12'hf00;
    localparam logic [5:0] MODE_RESET = 6'h00;

    // Pin vector layout after the synchronisers
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_LOAD_N = 3;
    localparam int PIN_RCV = 4;
    localparam int PIN_DATA = 8;
    localparam int PIN_UPPER = 12;
    localparam int PIN_LOWER = 16;
    localparam int PIN_COUNT = 20;

    // Idle pin levels: chip select high, load and everything else low
    localparam logic [19:0] PINS_IDLE = 20'h00002;

    // Driver output selection
    typedef enum logic [2:0] {
        DRV_LOW = 3'b000,
        DRV_HIGH = 3'b001,
        DRV_HIGH_Z = 3'b010,
        DRV_TERM = 3'b011,
        DRV_LOW_LEAK = 3'b100
    } drv_mode_t;

    // Six mode bits of one channel, bit 0 at the right
    typedef struct packed {
        logic load_high_en;
        logic load_low_en;
        logic force_en;
        logic sense_en;
        logic low_leak_select;
        logic term_en;
    } mode_bits_t;

    // Everything one channel drives toward the analog section
    typedef struct packed {
        drv_mode_t drv_mode;
        logic sense_closed;
        logic force_closed;
        logic load_low_on;
        logic load_high_on;
        logic upper_compare_out;
        logic lower_compare_out;
    } chan_out_t;

    // Fast per-channel pins
    typedef struct packed {
        logic [3:0] receive_select;
        logic [3:0] drive_level_select;
        logic [3:0] above_upper_threshold;
        logic [3:0] above_lower_threshold;
    } chan_pins_t;

endpackage

/* File: hw/pin_channel_mode_control.sv */
// Contract
// - Twelve-bit word shifts in MSB first; captured when chip select rises.
// - Mode bits go only to channels whose select bit D8..D11 is set.
// - Load input low: input word passes to selected channels without serial clock.
// - Load tied low: selected channels update at chip select rising edge.
// - Six mode bits in positions 0..5; bits 6 and 7 ignored.
// - Bit 0 termination select, bit 1 low-leak select.
// - Bit 2 closes sense switch, bit 3 closes force switch, per channel.
// - Bit 4 enables low-value load path, bit 5 high-value path.
// - Both load paths independent: none, either, or both connected.
// - Power-up: mode bits zero, four channel-select bits one.
// - Drive mode: drive-level select picks low or high reference; termination ignored.
// - Receive mode: termination bit picks high impedance or termination reference.
// - Low-leak bit overrides receive, drive-level and termination inputs.
// - Compare outputs follow pin-above-threshold results, independently.
// - Low-leak state is held separately for every channel.
// - Load input rising edge transfers input word; transparent while low.
`timescale 1ns/100ps
`default_nettype none

module pin_channel_mode_control
    import pin_channel_pkg::*;
(
    // Clock and synchronous reset
    input wire logic clk,
    input wire logic reset,
    // Serial port and load pins, asynchronous to clk
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic latch_load_n,
    // Fast per-channel pins, also asynchronous
    input wire chan_pins_t chan_pins,
    // Registered controls toward the analog section
    output var chan_out_t [3:0] chan_out,
    // Captured word and low-leak bits for observation
    output logic [11:0] input_word,
    output logic [3:0] low_leak_channels
);

    // All pins gathered into one vector for a common synchroniser
    logic [PIN_COUNT-1:0] pins_raw;
    assign pins_raw = {chan_pins.above_lower_threshold, chan_pins.above_upper_threshold,
                       chan_pins.drive_level_select, chan_pins.receive_select,
                       latch_load_n, din, cs_n, sclk};

    logic [PIN_COUNT-1:0] sync1_ff;
    logic [PIN_COUNT-1:0] sync2_ff;
    logic [PIN_COUNT-1:0] sync3_ff;
    logic [PIN_COUNT-1:0] pins_ff;
    logic [PIN_COUNT-1:0] nxt_pins;

    // Three stages; a level is accepted only once stages two and three agree
    // A one-cycle glitch on a pin is therefore never seen
    genvar gp;
    generate
        for (gp = 0; gp < PIN_COUNT; gp++) begin : g_sync
            assign nxt_pins[gp] = (sync2_ff[gp] == sync3_ff[gp]) ? sync3_ff[gp] : pins_ff[gp];
        end
    endgenerate

    // Synchroniser chain; all stages start at the idle pin levels, so
    // no chip select or load edge is invented right after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_ff <= PINS_IDLE;
            sync2_ff <= PINS_IDLE;
            sync3_ff <= PINS_IDLE;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Filtered levels; also the previous-cycle reference for edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            pins_ff <= PINS_IDLE;
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    // Accepted level of each serial pin for this cycle
    wire sclk_lvl = nxt_pins[PIN_SCLK];
    wire cs_n_lvl = nxt_pins[PIN_CS_N];
    wire din_lvl = nxt_pins[PIN_DIN];
    wire load_n_lvl = nxt_pins[PIN_LOAD_N];

    // Level accepted one cycle earlier, the reference for edges
    wire sclk_prev = pins_ff[PIN_SCLK];
    wire cs_n_prev = pins_ff[PIN_CS_N];
    wire load_n_prev = pins_ff[PIN_LOAD_N];

    // Edge detection on the filtered serial pins
    wire sclk_rise = sclk_lvl & ~sclk_prev;
    wire cs_low = cs_n_prev == 1'b0;
    wire cs_rise = cs_n_lvl & ~cs_n_prev;
    wire load_low = load_n_lvl == 1'b0;
    wire load_rise = load_n_lvl & ~load_n_prev;
    // Chip select must rise after the last clock edge was accepted,
    // otherwise that last bit misses the captured word
    wire shift_en = sclk_rise & cs_low;

    // Shift register and captured input word
    logic [11:0] shift_ff;
    logic [11:0] nxt_shift;
    logic [11:0] word_ff;
    logic [11:0] nxt_word;

    // Shift MSB first; excess edges push older bits out the top, and a
    // short frame leaves bits of the previous frame in the upper positions
    assign nxt_shift = shift_en ? {shift_ff[10:0], din_lvl} : shift_ff;
    // Input word captured only at the end of a frame
    assign nxt_word = cs_rise ? shift_ff : word_ff;

    // Serial shift register
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_ff <= WORD_RESET;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    // Input word; power-up value selects every channel
    always_ff @(posedge clk) begin
        if (reset) begin
            word_ff <= WORD_RESET;
        end else begin
            word_ff <= nxt_word;
        end
    end

    // Transfer condition: transparent while load low, or at its rising edge.
    // With load tied low the word itself changes at chip select rise, so the
    // channels follow it on the same edge.
    wire transfer = load_low | load_rise;
    // Bits 6 and 7 never reach a latch
    wire [5:0] new_mode = nxt_word[MODE_BITS-1:0];

    // Per-channel latches and the values they feed
    mode_bits_t [3:0] mode_ff;
    mode_bits_t [3:0] nxt_mode;
    drv_mode_t [3:0] nxt_drv;
    chan_out_t [3:0] nxt_out;

    genvar gc;
    generate
        for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
            wire selected = nxt_word[SELECT_LSB + gc];
            // Fast pins of this channel, already filtered
            wire rcv = pins_ff[PIN_RCV + gc];
            wire lvl = pins_ff[PIN_DATA + gc];
            wire above_upper = pins_ff[PIN_UPPER + gc];
            wire above_lower = pins_ff[PIN_LOWER + gc];

            // Each channel keeps its own latch, so low-leak is per channel
            assign nxt_mode[gc] = (transfer && selected) ? mode_bits_t'(new_mode) : mode_ff[gc];

            // Latched bits that steer the driver
            wire leak_on = mode_ff[gc].low_leak_select;
            wire term_on = mode_ff[gc].term_en;

            // Driver choice; low-leak wins over every fast pin and the term bit
            wire pick_term = ~leak_on & rcv & term_on;
            wire pick_high_z = ~leak_on & rcv & ~term_on;
            wire pick_high = ~leak_on & ~rcv & lvl;

            // Termination bit is a don't-care while driving
            assign nxt_drv[gc] = leak_on ? DRV_LOW_LEAK :
                                 pick_term ? DRV_TERM :
                                 pick_high_z ? DRV_HIGH_Z :
                                 pick_high ? DRV_HIGH : DRV_LOW;

            assign nxt_out[gc].drv_mode = nxt_drv[gc];
            assign nxt_out[gc].sense_closed = mode_ff[gc].sense_en;
            assign nxt_out[gc].force_closed = mode_ff[gc].force_en;
            // Separate switches, so all four load combinations are reachable
            assign nxt_out[gc].load_low_on = mode_ff[gc].load_low_en;
            assign nxt_out[gc].load_high_on = mode_ff[gc].load_high_en;

            // Comparator results pass straight through, one bit each
            assign nxt_out[gc].upper_compare_out = above_upper;
            assign nxt_out[gc].lower_compare_out = above_lower;
            assign low_leak_channels[gc] = mode_ff[gc].low_leak_select;
        end
    endgenerate

    chan_out_t [3:0] out_ff;

    // Channel latches; they change only on a transfer with their
    // select bit set, so unselected channels keep their mode
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_ff <= {CHANNELS{MODE_RESET}};
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Registered channel outputs; reset leaves the driver at the low level
    always_ff @(posedge clk) begin
        if (reset) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    // Outputs come straight from flip-flops; the fast pins see five
    // cycles of latency, which the analog timing must allow for
    assign chan_out = out_ff;
    assign input_word = word_ff;

endmodule

`default_nettype wire

/* File: testbench/serial_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_ctrl_model (
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // Idle frame state: clock parked low, device deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // One bit every 80 ns; data moves only while the clock is low
    task automatic send(input logic [15:0] word, input int bits);
        cs_n = 1'b0;
        for (int i = bits - 1; i >= 0; i--) begin
            din = word[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        din = ~din; // Data line inverted, old value not kept
    endtask
endmodule

`default_nettype wire

/* File: testbench/pin_channel_mode_props.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_channel_mode_props
    import pin_channel_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire chan_pins_t chan_pins,
    input wire chan_out_t [3:0] chan_out,
    input wire logic [11:0] input_word,
    input wire logic [3:0] low_leak_channels
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Power-up values must already stand while reset is held
    chk_reset_word: assert property (disable iff (1'b0) reset |=> input_word == 12'hf00)
        else $error("input word not at power-up value");
    chk_reset_leak: assert property (disable iff (1'b0) reset |=> low_leak_channels == 4'h0)
        else $error("low leak set after reset");
    // Low leak overrides every fast pin, one cycle after the latch
    chk_leak_drv: assert property (low_leak_channels[0] |=> chan_out[0].drv_mode == DRV_LOW_LEAK)
        else $error("channel one not in low leak");
    chk_no_leak: assert property (!low_leak_channels[1] |=> chan_out[1].drv_mode != DRV_LOW_LEAK)
        else $error("channel two low leak without its bit");
    // Comparator path is five cycles deep from the pins
    chk_upper_follow: assert property (chan_out[0].upper_compare_out == $past(chan_pins.above_upper_threshold[0], 5))
        else $error("upper compare wrong");
    chk_lower_follow: assert property (chan_out[3].lower_compare_out == $past(chan_pins.above_lower_threshold[3], 5))
        else $error("lower compare wrong");
    // Only selected channels may change, and only to the word's bit
    chk_select_only: assert property ($changed(low_leak_channels) |-> ((low_leak_channels ^ $past(low_leak_channels))
        & ~(input_word[11:8] | $past(input_word[11:8]))) == 4'h0) else $error("unselected channel changed");
    chk_leak_value: assert property ($changed(low_leak_channels) |-> ((low_leak_channels ^ $past(low_leak_channels))
        & (low_leak_channels ^ {4{input_word[LOW_LEAK_BIT]}})) == 4'h0) else $error("leak bit not from word");
    chk_word_on_cs: assert property ($changed(input_word) |-> cs_n && $past(cs_n, 3))
        else $error("word changed inside a frame");

    cover property (low_leak_channels[1]);
    cover property (chan_out[0].drv_mode == DRV_TERM);
    cover property ($changed(input_word));
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import pin_channel_pkg::*;
    logic clk, reset, sclk, cs_n, din, latch_load_n;
    chan_pins_t chan_pins;
    chan_out_t [3:0] chan_out;
    logic [11:0] input_word;
    logic [3:0] low_leak_channels;
    int fail_count = 0;
    int check_count = 0;

    pin_channel_mode_control u_pin_channel_mode_control(.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
        .din(din), .latch_load_n(latch_load_n), .chan_pins(chan_pins), .chan_out(chan_out),
        .input_word(input_word), .low_leak_channels(low_leak_channels));
    serial_ctrl_model u_serial_ctrl_model(.sclk(sclk), .cs_n(cs_n), .din(din));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Fast pins are synchronised, so allow eight cycles to settle
    task automatic drive_case(input logic rcv, input logic lvl, input drv_mode_t exp);
        chan_pins.receive_select[0] = rcv;
        chan_pins.drive_level_select[0] = lvl;
        wait_clk(8);
        check("drv_mode", {9'h0, exp}, {9'h0, chan_out[0].drv_mode});
    endtask

    task automatic tied_low_frame;
        u_serial_ctrl_model.send(16'h02c2, 12);
        wait_clk(8);
        check("input_word", 12'h2c2, input_word);
        check("low_leak", 12'h002, {8'h0, low_leak_channels});
        check("ch2 drv", {9'h0, DRV_LOW_LEAK}, {9'h0, chan_out[1].drv_mode});
        u_serial_ctrl_model.send(16'h3101, 14);
        wait_clk(8);
        check("input_word", 12'h101, input_word);
        check("low_leak", 12'h002, {8'h0, low_leak_channels});
    endtask

    task automatic latched_frame;
        latch_load_n = 1'b1;
        wait_clk(8);
        u_serial_ctrl_model.send(16'h013d, 12);
        wait_clk(8);
        check("held mode", 12'h000, {8'h0, chan_out[0][5:2]});
        latch_load_n = 1'b0;
        wait_clk(8);
        check("switches", 12'h00f, {8'h0, chan_out[0][5:2]});
        drive_case(1'b1, 1'b0, DRV_TERM);
        drive_case(1'b0, 1'b0, DRV_LOW);
        latch_load_n = 1'b1;
        u_serial_ctrl_model.send(16'h0110, 12);
        wait_clk(8);
        check("held mode", 12'h00f, {8'h0, chan_out[0][5:2]});
        latch_load_n = 1'b0;
        wait_clk(8);
        check("load path", 12'h002, {8'h0, chan_out[0][5:2]});
        drive_case(1'b1, 1'b1, DRV_HIGH_Z);
        drive_case(1'b0, 1'b1, DRV_HIGH);
    endtask

    task automatic compare_pins;
        chan_pins.above_upper_threshold = 4'h1;
        chan_pins.above_lower_threshold = 4'h8;
        wait_clk(8);
        check("compare", 12'h009, {8'h0, chan_out[0].upper_compare_out, chan_out[0].lower_compare_out,
            chan_out[3].upper_compare_out, chan_out[3].lower_compare_out});
    endtask

    // Unused channels parked in low leak; channel one ignores its fast pins
    task automatic park_unused;
        u_serial_ctrl_model.send(16'h0d02, 12);
        wait_clk(8);
        check("low_leak", 12'h00f, {8'h0, low_leak_channels});
        check("ch1 drv", {9'h0, DRV_LOW_LEAK}, {9'h0, chan_out[0].drv_mode});
        check("ch4 drv", {9'h0, DRV_LOW_LEAK}, {9'h0, chan_out[3].drv_mode});
    endtask

    // Main sequence; load input starts tied low
    initial begin
        reset = 1'b1;
        latch_load_n = 1'b0;
        chan_pins = '0;
        wait_clk(20);
        reset = 1'b0;
        wait_clk(2);
        check("reset word", 12'hf00, input_word);
        check("reset ch1", 12'h000, {3'h0, chan_out[0]});
        tied_low_frame();
        latched_frame();
        compare_pins();
        park_unused();
        stop_test();
    end
endmodule

bind pin_channel_mode_control pin_channel_mode_props u_pin_channel_mode_props(.clk(clk), .reset(reset),
    .cs_n(cs_n), .chan_pins(chan_pins), .chan_out(chan_out), .input_word(input_word),
    .low_leak_channels(low_leak_channels));

`default_nettype wire
